// [sfs_map.vh]
// field positions, codes and reset values of the slot format block
`ifndef SFS_MAP_VH
`define SFS_MAP_VH
`define SFS_CFG_W         16
`define SFS_CFG_RESET     16'h1000
`define SFS_CFG_WMASK     16'h31fd
`define SFS_A_EN          0
`define SFS_A_FMT_LO      2
`define SFS_A_FMT_HI      4
`define SFS_B_EN          5
`define SFS_B_FMT_LO      6
`define SFS_B_FMT_HI      8
`define SFS_OVWR_BLOCK    12
`define SFS_FMT_NONE      3'h0
`define SFS_FMT_SUM16     3'h1
`define SFS_FMT_SUM32     3'h2
`define SFS_FMT_CH16      3'h4
`define SFS_FMT_CH32      3'h6
`define SFS_CNT_NONE      4'h0
`define SFS_CNT_SUM16     4'h1
`define SFS_CNT_SUM32     4'h2
`define SFS_CNT_CH16      4'h4
`define SFS_CNT_CH32      4'h8
`define SFS_ROOM_W        9
`define SFS_ROOM_PAD      5'h00
`define SFS_IDX_ZERO      3'h0
`define SFS_IDX_ONE       3'h1
`define SFS_WORD_W        16
`define SFS_CHAN_W        32
`define SFS_NUM_CH        4
`define SFS_AVG_W         3
`endif

// [sfs_skid_buf.v]
// two-entry word buffer with valid/ready on both sides
`timescale 1ns/100ps
`default_nettype none
`include "sfs_map.vh"
module sfs_skid_buf
(
  input  wire                   clock,
  input  wire                   srst,
  input  wire                   inValid,
  output wire                   inReady,
  input  wire [`SFS_WORD_W-1:0] inData,
  output wire                   outValid,
  input  wire                   outReady,
  output wire [`SFS_WORD_W-1:0] outData
);
  reg [`SFS_WORD_W-1:0] store [0:1];
  reg                   wrPtr;
  reg                   rdPtr;
  reg [1:0]             fill;
  wire                  doWrite;
  wire                  doRead;

  assign inReady  = (fill != 2'h2);
  assign outValid = (fill != 2'h0);
  assign outData  = store[rdPtr];
  assign doWrite  = inValid & inReady;
  assign doRead   = outValid & outReady;

  always @(posedge clock)
  begin
    if (srst)
    begin
      wrPtr <= 1'b0;
      rdPtr <= 1'b0;
      fill  <= 2'h0;
    end
    else
    begin
      if (doWrite)
      begin
        store[wrPtr] <= inData;
        wrPtr        <= ~wrPtr;
      end
      if (doRead)
        rdPtr <= ~rdPtr;
      if (doWrite & ~doRead)
        fill <= fill + 2'h1;
      else if (doRead & ~doWrite)
        fill <= fill - 2'h1;
    end
  end
endmodule
`default_nettype wire

// [sfs_slot_fifo_format.v]
// slot enable and fifo format selection with word serializer
`timescale 1ns/100ps
`default_nettype none
`include "sfs_map.vh"
module sfs_slot_fifo_format
(
  input  wire                     clock,
  input  wire                     srst,
  input  wire                     cfgWrite,
  input  wire [`SFS_CFG_W-1:0]    cfgWdata,
  output wire [`SFS_CFG_W-1:0]    cfgRdata,
  input  wire [`SFS_AVG_W-1:0]    avgFactorA,
  input  wire [`SFS_AVG_W-1:0]    avgFactorB,
  output wire                     slotARun,
  output wire                     slotBRun,
  input  wire                     resultAValid,
  input  wire [4*`SFS_CHAN_W-1:0] resultA,
  input  wire                     resultBValid,
  input  wire [4*`SFS_CHAN_W-1:0] resultB,
  input  wire [`SFS_ROOM_W-1:0]   fifoRoom,
  output wire                     fifoWrapAllow,
  output wire                     fifoWordValid,
  input  wire                     fifoWordReady,
  output wire [`SFS_WORD_W-1:0]   fifoWord,
  output reg                      resultDropped
);
  localparam [2:0] ST_IDLE  = 3'h1;
  localparam [2:0] ST_SENDA = 3'h2;
  localparam [2:0] ST_SENDB = 3'h4;

  reg  [`SFS_CFG_W-1:0]    cfg;
  reg  [4*`SFS_CHAN_W-1:0] chanA;
  reg  [4*`SFS_CHAN_W-1:0] chanB;
  reg  [`SFS_CHAN_W-1:0]   sumA;
  reg  [`SFS_CHAN_W-1:0]   sumB;
  reg                      pendA;
  reg                      pendB;
  reg  [2:0]               state;
  reg  [2:0]               next_state;
  reg  [2:0]               wordIdx;
  reg  [`SFS_WORD_W-1:0]   curWord;
  reg  [3:0]               curCount;
  wire [2:0]               fmtA;
  wire [2:0]               fmtB;
  wire                     storeA;
  wire                     storeB;
  wire                     blockWrap;
  wire                     fitA;
  wire                     fitB;
  wire                     takeA;
  wire                     takeB;
  wire                     bufInValid;
  wire                     bufInReady;
  wire                     lastWord;

  // words per result for a format code; reserved codes store nothing
  function [3:0] wordCount;
    input [2:0] fmt;
    begin
      case (fmt)
        `SFS_FMT_SUM16: wordCount = `SFS_CNT_SUM16;
        `SFS_FMT_SUM32: wordCount = `SFS_CNT_SUM32;
        `SFS_FMT_CH16:  wordCount = `SFS_CNT_CH16;
        `SFS_FMT_CH32:  wordCount = `SFS_CNT_CH32;
        default:        wordCount = `SFS_CNT_NONE;
      endcase
    end
  endfunction

  // wrapping sum of the four channel values; carries beyond the word are lost
  function [`SFS_CHAN_W-1:0] chanSum;
    input [4*`SFS_CHAN_W-1:0] chans;
    integer                   n;
    begin
      chanSum = `SFS_CHAN_W'h0;
      for (n = 0; n < `SFS_NUM_CH; n = n + 1)
        chanSum = chanSum + chans[n*`SFS_CHAN_W +: `SFS_CHAN_W];
    end
  endfunction

  // 16-bit word number idx of one result; 32-bit values go upper half first
  function [`SFS_WORD_W-1:0] wordOf;
    input [2:0]                 fmt;
    input [2:0]                 idx;
    input [`SFS_CHAN_W-1:0]     sum;
    input [4*`SFS_CHAN_W-1:0]   chans;
    reg   [`SFS_CHAN_W-1:0]     ch;
    begin
      ch = `SFS_CHAN_W'h0;
      case (fmt)
        `SFS_FMT_SUM16:
          wordOf = sum[`SFS_WORD_W-1:0];
        `SFS_FMT_SUM32:
          wordOf = (idx == `SFS_IDX_ZERO) ? sum[`SFS_CHAN_W-1:`SFS_WORD_W]
                                          : sum[`SFS_WORD_W-1:0];
        `SFS_FMT_CH16:
        begin
          ch     = chans[idx[1:0]*`SFS_CHAN_W +: `SFS_CHAN_W];
          wordOf = ch[`SFS_WORD_W-1:0];
        end
        `SFS_FMT_CH32:
        begin
          ch     = chans[idx[2:1]*`SFS_CHAN_W +: `SFS_CHAN_W];
          wordOf = idx[0] ? ch[`SFS_WORD_W-1:0]
                          : ch[`SFS_CHAN_W-1:`SFS_WORD_W];
        end
        default:
          wordOf = `SFS_WORD_W'h0;
      endcase
    end
  endfunction

  assign fmtA      = cfg[`SFS_A_FMT_HI:`SFS_A_FMT_LO];
  assign fmtB      = cfg[`SFS_B_FMT_HI:`SFS_B_FMT_LO];
  assign slotARun  = cfg[`SFS_A_EN];
  assign slotBRun  = cfg[`SFS_B_EN];
  assign blockWrap = cfg[`SFS_OVWR_BLOCK];
  assign fifoWrapAllow = ~blockWrap;
  assign cfgRdata  = cfg;

  assign storeA = slotARun & (wordCount(fmtA) != `SFS_CNT_NONE);
  assign storeB = slotBRun & (wordCount(fmtB) != `SFS_CNT_NONE)
                & ((fmtA == `SFS_FMT_NONE) | (avgFactorA == avgFactorB));

  // while wrap is blocked, room is judged per whole result; slots A and B are each judged against the whole fifoRoom
  assign fitA  = ~blockWrap | (fifoRoom >= {`SFS_ROOM_PAD, wordCount(fmtA)});
  assign fitB  = ~blockWrap | (fifoRoom >= {`SFS_ROOM_PAD, wordCount(fmtB)});
  assign takeA = resultAValid & storeA & ~pendA & fitA;
  assign takeB = resultBValid & storeB & ~pendB & fitB;

  assign bufInValid = state[1] | state[2];
  assign lastWord   = ({1'b0, wordIdx} + 4'h1) == curCount;

  always @*
  begin
    curWord  = `SFS_WORD_W'h0;
    curCount = `SFS_CNT_NONE;
    if (state[1])
    begin
      curWord  = wordOf(fmtA, wordIdx, sumA, chanA);
      curCount = wordCount(fmtA);
    end
    else if (state[2])
    begin
      curWord  = wordOf(fmtB, wordIdx, sumB, chanB);
      curCount = wordCount(fmtB);
    end
  end

  always @*
  begin
    next_state = state;
    case (state)
      ST_IDLE:
        if (pendA)
          next_state = ST_SENDA;
        else if (pendB)
          next_state = ST_SENDB;
      ST_SENDA:
        if (bufInReady & lastWord)
          next_state = pendB ? ST_SENDB : ST_IDLE;
      ST_SENDB:
        if (bufInReady & lastWord)
          next_state = ST_IDLE;
      default:
        next_state = ST_IDLE;
    endcase
  end

  always @(posedge clock)
  begin
    if (srst)
    begin
      cfg           <= `SFS_CFG_RESET;
      pendA         <= 1'b0;
      pendB         <= 1'b0;
      state         <= ST_IDLE;
      wordIdx       <= `SFS_IDX_ZERO;
      resultDropped <= 1'b0;
      chanA         <= {4*`SFS_CHAN_W{1'b0}};
      chanB         <= {4*`SFS_CHAN_W{1'b0}};
      sumA          <= `SFS_CHAN_W'h0;
      sumB          <= `SFS_CHAN_W'h0;
    end
    else
    begin
      if (cfgWrite)
        cfg <= cfgWdata & `SFS_CFG_WMASK;
      state <= next_state;
      // a result arriving while its slot still drains is dropped and flagged
      resultDropped <= (resultAValid & storeA & ~takeA)
                     | (resultBValid & storeB & ~takeB);
      if (takeA)
      begin
        chanA <= resultA;
        sumA  <= chanSum(resultA);
        pendA <= 1'b1;
      end
      else if ((state == ST_SENDA) & bufInReady & lastWord)
        pendA <= 1'b0;
      if (takeB)
      begin
        chanB <= resultB;
        sumB  <= chanSum(resultB);
        pendB <= 1'b1;
      end
      else if ((state == ST_SENDB) & bufInReady & lastWord)
        pendB <= 1'b0;
      if (bufInValid & bufInReady)
        wordIdx <= lastWord ? `SFS_IDX_ZERO : wordIdx + `SFS_IDX_ONE;
    end
  end

  sfs_skid_buf wordBuf
  (
    .clock    (clock),
    .srst     (srst),
    .inValid  (bufInValid),
    .inReady  (bufInReady),
    .inData   (curWord),
    .outValid (fifoWordValid),
    .outReady (fifoWordReady),
    .outData  (fifoWord)
  );
endmodule
`default_nettype wire

// [sfs_slot_fifo_format_chk.sv]
// port checker of the slot format block
`timescale 1ns/100ps
`default_nettype none
module sfs_slot_fifo_format_chk
(
  input wire logic         clock,
  input wire logic         srst,
  input wire logic         cfgWrite,
  input wire logic [15:0]  cfgWdata,
  input wire logic [15:0]  cfgRdata,
  input wire logic [2:0]   avgFactorA,
  input wire logic [2:0]   avgFactorB,
  input wire logic         slotARun,
  input wire logic         slotBRun,
  input wire logic         resultAValid,
  input wire logic [127:0] resultA,
  input wire logic         resultBValid,
  input wire logic [127:0] resultB,
  input wire logic [8:0]   fifoRoom,
  input wire logic         fifoWrapAllow,
  input wire logic         fifoWordValid,
  input wire logic         fifoWordReady,
  input wire logic [15:0]  fifoWord,
  input wire logic         resultDropped
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);
  property p_cfg;
    cfgWrite |=> cfgRdata == ($past(cfgWdata) & 16'h31fd);
  endproperty
  a_cfg: assert property (p_cfg) else $error("register value wrong");
  property p_arun;
    cfgWrite |=> slotARun == $past(cfgWdata[0]);
  endproperty
  a_arun: assert property (p_arun) else $error("slot A run wrong");
  property p_brun;
    cfgWrite |=> slotBRun == $past(cfgWdata[5]);
  endproperty
  a_brun: assert property (p_brun) else $error("slot B run wrong");
  property p_wrap;
    cfgWrite |=> fifoWrapAllow == !$past(cfgWdata[12]);
  endproperty
  a_wrap: assert property (p_wrap) else $error("wrap flag wrong");
  property p_rst;
    $fell(srst) |-> cfgRdata == 16'h1000 && !fifoWrapAllow && !fifoWordValid;
  endproperty
  a_rst: assert property (p_rst) else $error("reset state wrong");
  // a stalled word must not change or vanish
  property p_hold;
    fifoWordValid && !fifoWordReady |=> fifoWordValid && $stable(fifoWord);
  endproperty
  a_hold: assert property (p_hold) else $error("stalled word lost");
  property p_boff;
    resultBValid && !resultAValid && cfgRdata[8:6] == 3'h0 |=> !resultDropped;
  endproperty
  a_boff: assert property (p_boff) else $error("slot B code zero dropped");
  property p_avg;
    resultBValid && !resultAValid && cfgRdata[4:2] != 3'h0 && avgFactorA != avgFactorB
      |=> !resultDropped;
  endproperty
  a_avg: assert property (p_avg) else $error("blocked slot B reported");
  property p_aoff;
    resultAValid && !resultBValid && (!slotARun || cfgRdata[4:2] == 3'h0) |=> !resultDropped;
  endproperty
  a_aoff: assert property (p_aoff) else $error("idle slot A reported");
  property p_full;
    resultAValid && !resultBValid && slotARun && cfgRdata[4:2] == 3'h1 && cfgRdata[12]
      && fifoRoom == 9'h0 |=> resultDropped;
  endproperty
  a_full: assert property (p_full) else $error("full drop not flagged");
  c_drop: cover property (resultDropped);
  c_stall: cover property (fifoWordValid && !fifoWordReady);
  c_both: cover property (resultAValid && resultBValid && slotBRun);
endmodule
`default_nettype wire

// [tb_top.sv]
// self-checking bench of the slot format block
`timescale 1ns/100ps
`default_nettype none
`define CHK(a,b) begin checked++; if ((a) !== (b)) begin num_errors++; \
  $display("unexpected at %0t: %h vs %h", $time, a, b); end end
module tb_top;
  logic clock = 0, srst = 1, cfgWrite = 0, resultAValid = 0, resultBValid = 0;
  logic fifoWordReady = 1, slotARun, slotBRun, fifoWrapAllow, fifoWordValid, resultDropped;
  logic [15:0] cfgWdata = 0, cfgRdata, fifoWord;
  logic [2:0] avgFactorA = 0, avgFactorB = 0;
  logic [8:0] fifoRoom = 9'h1ff;
  logic [127:0] resultA = 128'h77778888555566663333444411112222;
  logic [127:0] resultB = 128'hf00d000ecafe000bbeef0009dead0001;
  logic [1:0] ph = 0;
  logic [15:0] got[$], exp[$];
  int num_errors = 0, checked = 0;
  logic [2:0] codes[4] = '{3'h1, 3'h2, 3'h4, 3'h6};
  sfs_slot_fifo_format dut_u (.*);
  always #12.5 clock = ~clock;
  // one stalled cycle in four keeps the buffer busy
  always @(posedge clock)
  begin
    ph <= ph + 2'h1;
    fifoWordReady <= ph != 2'h0;
    if (!srst && fifoWordValid && fifoWordReady) got.push_back(fifoWord);
  end
  function automatic logic [15:0] cfg(logic ae, logic [2:0] af, logic be, logic [2:0] bf);
    return {3'h0, 1'b1, 3'h0, bf, be, af, 1'b0, ae};
  endfunction
  task automatic wr(logic [15:0] d);
    cfgWrite <= 1'b1;
    cfgWdata <= d;
    @(posedge clock);
    cfgWrite <= 1'b0;
    @(posedge clock);
  endtask
  task automatic res(logic a, logic b);
    resultAValid <= a;
    resultBValid <= b;
    @(posedge clock);
    resultAValid <= 1'b0;
    resultBValid <= 1'b0;
    @(posedge clock);
  endtask
  task automatic push_words(logic [2:0] c, logic [127:0] ch);
    logic [31:0] s;
    s = ch[31:0] + ch[63:32] + ch[95:64] + ch[127:96];
    if (c == 3'h1) exp.push_back(s[15:0]);
    if (c == 3'h2) begin exp.push_back(s[31:16]); exp.push_back(s[15:0]); end
    for (int i = 0; i < 4; i++)
    begin
      if (c == 3'h6) exp.push_back(ch[32*i+16 +: 16]);
      if (c[2]) exp.push_back(ch[32*i +: 16]);
    end
  endtask
  task automatic cmpq;
    for (int n = 0; n < 80 && got.size() < exp.size(); n++) @(posedge clock);
    repeat (8) @(posedge clock);
    `CHK(got.size(), exp.size())
    foreach (exp[i]) if (i < got.size()) `CHK(got[i], exp[i])
    got.delete();
    exp.delete();
  endtask
  task automatic tally_and_finish;
    if (num_errors == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial
  begin
    #300000;
    num_errors++;
    tally_and_finish;
  end
  initial
  begin
    repeat (8) @(posedge clock);
    srst <= 1'b0;
    #1 `CHK({cfgRdata, fifoWrapAllow, resultDropped}, {16'h1000, 2'h0})
    `CHK({slotARun, slotBRun, fifoWordValid}, 3'h0)
    @(posedge clock);
    wr(16'hffff);
    `CHK({cfgRdata, slotARun, slotBRun}, {16'h31fd, 2'h3})
    for (int s = 0; s < 2; s++)
      foreach (codes[k])
      begin
        wr(s == 1 ? cfg(1'b0, 3'h0, 1'b1, codes[k]) : cfg(1'b1, codes[k], 1'b0, 3'h0));
        res(s == 0, s == 1);
        push_words(codes[k], s == 1 ? resultB : resultA);
        cmpq();
      end
    wr(cfg(1'b1, 3'h1, 1'b1, 3'h4));
    res(1'b1, 1'b1);
    push_words(3'h1, resultA);
    push_words(3'h4, resultB);
    cmpq();
    // disabled slot, code zero and reserved codes store nothing; mismatched averaging blocks slot B
    avgFactorA <= 3'h1;
    wr(cfg(1'b0, 3'h1, 1'b1, 3'h0));
    res(1'b1, 1'b0);
    res(1'b0, 1'b1);
    wr(cfg(1'b1, 3'h3, 1'b1, 3'h5));
    res(1'b1, 1'b0);
    res(1'b0, 1'b1);
    wr(cfg(1'b1, 3'h1, 1'b1, 3'h1));
    res(1'b0, 1'b1);
    cmpq();
    // slot A silent, so slot B stores despite the mismatch
    wr(cfg(1'b0, 3'h0, 1'b1, 3'h1));
    res(1'b0, 1'b1);
    push_words(3'h1, resultB);
    cmpq();
    avgFactorA <= 3'h0;
    // room of exactly one result still stores it
    fifoRoom <= 9'h001;
    wr(cfg(1'b1, 3'h1, 1'b0, 3'h0));
    res(1'b1, 1'b0);
    push_words(3'h1, resultA);
    cmpq();
    // no room: pulse stands one cycle after the refused result
    fifoRoom <= 9'h000;
    resultAValid <= 1'b1;
    @(posedge clock);
    resultAValid <= 1'b0;
    #1 `CHK(resultDropped, 1'b1)
    @(posedge clock);
    cmpq();
    wr(16'h0005);
    `CHK(fifoWrapAllow, 1'b1)
    res(1'b1, 1'b0);
    push_words(3'h1, resultA);
    cmpq();
    tally_and_finish;
  end
endmodule
bind sfs_slot_fifo_format sfs_slot_fifo_format_chk chk_u (.*);
`undef CHK
`default_nettype wire
